//--- core/ffol_top.sv
// Flag offset loader: the almost-empty and almost-full offset registers with
// serial loading on the serial clock and parallel loading and readback on clock.
// Assumes the host drives the write and read ports synchronously to clock and
// the serial pins synchronously to serial_clock.
`timescale 1ns/1ps
`include "ffol_map.svh"
module ffol_top #(
   parameter int BASE_BITS = `FFOL_MAX_BITS
) (
   // Clocks and reset
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   input  wire logic                       serial_clock,
   // Device resets and straps
   input  wire logic                       master_reset,
   input  wire logic                       partial_reset,
   input  wire logic                       serial_select,
   input  wire logic                       in_halfword,
   input  wire logic                       out_halfword,
   // Parallel port
   input  wire logic                       offset_load_strobe_n,
   input  wire logic                       write_enable_n,
   input  wire logic                       read_enable_n,
   input  wire logic [`FFOL_DATA_BITS-1:0] write_data_in,
   // Serial port
   input  wire logic                       serial_load_enable_n,
   input  wire logic                       serial_in,
   // Outputs
   output logic [`FFOL_DATA_BITS-1:0]      read_data_out,
   output logic [`FFOL_MAX_BITS-1:0]       empty_threshold_offset,
   output logic [`FFOL_MAX_BITS-1:0]       full_threshold_offset,
   output logic                            almost_empty_valid,
   output logic                            almost_full_valid,
   output logic                            serial_method,
   output logic                            memory_write,
   output logic                            memory_read
);

   localparam int SEGB = `FFOL_BYTE_SEG;
   localparam int SEGH = `FFOL_HALF_SEG;

   ffol_pkg::ffol_main_s m;
   ffol_pkg::ffol_main_s next_m;
   ffol_pkg::ffol_ser_s  s;
   ffol_pkg::ffol_ser_s  next_s;

   // Number of significant bits for the current width mode.
   function automatic logic [`FFOL_IDX_BITS-1:0] ofs_bits(input logic x9);
      int w;
      w = x9 ? BASE_BITS : BASE_BITS - 1;
      return w[`FFOL_IDX_BITS-1:0];
   endfunction : ofs_bits

   // Last segment index of one register for a port of the given width.
   function automatic logic [1:0] last_seg(input logic half, input logic x9);
      int w;
      int n;
      w = int'(ofs_bits(x9));
      n = half ? (w + SEGH - 1) / SEGH : (w + SEGB - 1) / SEGB;
      return 2'(n - 1);
   endfunction : last_seg

   // Segment of an offset value, right aligned on the data word.
   function automatic logic [`FFOL_DATA_BITS-1:0] get_seg(
      input ffol_pkg::ffol_ofs_t v,
      input logic [1:0] idx,
      input logic half);
      logic [`FFOL_MAX_BITS+SEGH*3-1:0] wide;
      logic [`FFOL_DATA_BITS-1:0] r;
      wide = {{(SEGH*3){1'b0}}, v};
      if (half) begin
         r = wide[int'(idx)*SEGH +: SEGH];
      end else begin
         r = {8'h00, wide[int'(idx)*SEGB +: SEGB]};
      end
      return r;
   endfunction : get_seg

   // Offset value with one segment replaced by new data.
   function automatic ffol_pkg::ffol_ofs_t put_seg(
      input ffol_pkg::ffol_ofs_t v,
      input logic [1:0] idx,
      input logic half,
      input logic [`FFOL_DATA_BITS-1:0] d);
      logic [`FFOL_MAX_BITS+SEGH*3-1:0] wide;
      wide = {{(SEGH*3){1'b0}}, v};
      if (half) begin
         wide[int'(idx)*SEGH +: SEGH] = d;
      end else begin
         wide[int'(idx)*SEGB +: SEGB] = d[SEGB-1:0];
      end
      return wide[`FFOL_MAX_BITS-1:0];
   endfunction : put_seg

   logic x9_mode;
   logic wr_go;
   logic rd_go;
   logic ser_done;
   logic [1:0] wr_last;
   logic [1:0] rd_last;

   // Standard and fall-through timing are not inputs here: loading is identical.
   assign x9_mode = ~m.in_half & ~m.out_half;
   assign wr_last = last_seg(m.in_half, x9_mode);
   assign rd_last = last_seg(m.out_half, x9_mode);
   assign wr_go   = ~m.serial_mode & ~offset_load_strobe_n & ~write_enable_n;
   assign rd_go   = ~offset_load_strobe_n & ~read_enable_n;
   assign ser_done = m.tog2 ^ m.tog3;

   // Strobe high sends both ports to the memory and keeps offsets out of it.
   assign memory_write = offset_load_strobe_n & ~write_enable_n;
   assign memory_read  = offset_load_strobe_n & ~read_enable_n;

   always_comb begin
      next_m = m;
      next_m.tog1 = s.tog;
      next_m.tog2 = m.tog1;
      next_m.tog3 = m.tog2;
      if (m.fwait != 2'h0) begin
         next_m.fwait = m.fwait - 2'h1;
         next_m.fvalid = (m.fwait == 2'h1);
      end
      if (m.ewait != 2'h0) begin
         next_m.ewait = m.ewait - 2'h1;
         next_m.evalid = (m.ewait == 2'h1);
      end
      // Only a complete serial set reaches the registers, both at once.
      if (ser_done && m.serial_mode) begin
         next_m.empty_ofs = s.hold_e;
         next_m.full_ofs  = s.hold_f;
         next_m.fvalid = 1'b0;
         next_m.evalid = 1'b0;
         next_m.fwait = `FFOL_SER_VALID;
         next_m.ewait = `FFOL_SER_VALID;
      end
      // Host keeps writes and reads apart; the pointers never share state.
      if (wr_go) begin
         if (m.wr_sel == ffol_pkg::FFOL_SEL_EMPTY) begin
            next_m.empty_ofs = put_seg(m.empty_ofs, m.wr_seg, m.in_half,
                                       write_data_in);
            next_m.evalid = 1'b0;
            next_m.ewait = (m.wr_seg == wr_last) ? `FFOL_PAR_VALID : 2'h0;
         end else begin
            next_m.full_ofs = put_seg(m.full_ofs, m.wr_seg, m.in_half,
                                      write_data_in);
            next_m.fvalid = 1'b0;
            next_m.fwait = (m.wr_seg == wr_last) ? `FFOL_PAR_VALID : 2'h0;
         end
         // A byte port walks one more segment per register.
         if (m.wr_seg == wr_last) begin
            next_m.wr_seg = 2'h0;
            next_m.wr_sel = (m.wr_sel == ffol_pkg::FFOL_SEL_EMPTY) ?
                            ffol_pkg::FFOL_SEL_FULL : ffol_pkg::FFOL_SEL_EMPTY;
         end else begin
            next_m.wr_seg = m.wr_seg + 2'h1;
         end
      end
      // Paused reads leave the pointer where it stood.
      if (rd_go) begin
         next_m.rdata = get_seg((m.rd_sel == ffol_pkg::FFOL_SEL_EMPTY) ?
                                m.empty_ofs : m.full_ofs,
                                m.rd_seg, m.out_half);
         if (m.rd_seg == rd_last) begin
            next_m.rd_seg = 2'h0;
            next_m.rd_sel = (m.rd_sel == ffol_pkg::FFOL_SEL_EMPTY) ?
                            ffol_pkg::FFOL_SEL_FULL : ffol_pkg::FFOL_SEL_EMPTY;
         end else begin
            next_m.rd_seg = m.rd_seg + 2'h1;
         end
      end
      // Partial reset deliberately leaves the pointers alone.
      if (partial_reset) begin
         next_m.rdata = '0;
      end
      if (master_reset) begin
         next_m.serial_mode = serial_select;
         next_m.in_half  = in_halfword;
         next_m.out_half = out_halfword;
         next_m.wr_sel = ffol_pkg::FFOL_SEL_EMPTY;
         next_m.wr_seg = 2'h0;
         next_m.rd_sel = ffol_pkg::FFOL_SEL_EMPTY;
         next_m.rd_seg = 2'h0;
         next_m.rdata  = '0;
         next_m.fwait  = 2'h0;
         next_m.ewait  = 2'h0;
         next_m.fvalid = 1'b0;
         next_m.evalid = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         m <= '0;
         m.empty_ofs <= `FFOL_OFS_RESET;
         m.full_ofs  <= `FFOL_OFS_RESET;
      end else begin
         m <= next_m;
      end
   end

   // Serial domain. The serial clock may stop between loads, so the finished
   // set is parked in hold registers and announced by a toggle; the main
   // domain copies it long before another full set can be shifted in.
   logic [`FFOL_IDX_BITS-1:0] ser_w;
   logic [`FFOL_IDX_BITS-1:0] ser_total;
   logic                      ser_go;
   ffol_pkg::ffol_ofs_t       e_new;
   ffol_pkg::ffol_ofs_t       f_new;

   assign ser_w     = ofs_bits(s.cfg2[1]);
   assign ser_total = ser_w + ser_w;
   // Either active-low strobe held high pauses the shift.
   assign ser_go    = s.cfg2[0] & ~offset_load_strobe_n & ~serial_load_enable_n;

   always_comb begin
      next_s = s;
      e_new = s.stage_e;
      f_new = s.stage_f;
      next_s.rst1 = sys_rst | master_reset;
      next_s.rst2 = s.rst1;
      next_s.cfg1 = {x9_mode, m.serial_mode};
      next_s.cfg2 = s.cfg1;
      if (ser_go) begin
         // Empty offset LSB first, full offset MSB last.
         if (s.idx < ser_w) begin
            e_new[s.idx[4:0]] = serial_in;
         end else begin
            f_new[5'(s.idx - ser_w)] = serial_in;
         end
         next_s.stage_e = e_new;
         next_s.stage_f = f_new;
         if (s.idx == ser_total - 6'h01) begin
            next_s.idx = '0;
            next_s.hold_e = e_new;
            next_s.hold_f = f_new;
            next_s.tog = ~s.tog;
         end else begin
            next_s.idx = s.idx + 6'h01;
         end
      end
   end

   always_ff @(posedge serial_clock) begin
      if (s.rst2) begin
         // The synchroniser keeps running in reset so the domain can leave it.
         s <= '0;
         s.rst1 <= next_s.rst1;
         s.rst2 <= next_s.rst2;
      end else begin
         s <= next_s;
      end
   end

   // Serial pins reach no logic in the main domain.
   assign read_data_out          = m.rdata;
   assign empty_threshold_offset = m.empty_ofs;
   assign full_threshold_offset  = m.full_ofs;
   assign almost_empty_valid     = m.evalid;
   assign almost_full_valid      = m.fvalid;
   assign serial_method          = m.serial_mode;

endmodule : ffol_top

//--- core/ffol_map.svh
// Offsets, field sizes, reset values and timing counts of the flag offset loader.
// Assumes inclusion by bare name from the package; holds defines only.
`ifndef FFOL_MAP_SVH
`define FFOL_MAP_SVH
`define FFOL_MAX_BITS      20
`define FFOL_BYTE_SEG      8
`define FFOL_HALF_SEG      16
`define FFOL_DATA_BITS     16
`define FFOL_IDX_BITS      6
`define FFOL_OFS_RESET     20'h0_0000
`define FFOL_SER_VALID     2'h3
`define FFOL_PAR_VALID     2'h2
`endif

//--- core/ffol_pkg.sv
// Types shared by the flag offset loader.
// Assumes the map header sits beside it in core/.
`include "ffol_map.svh"
package ffol_pkg;
   typedef enum logic {FFOL_SEL_EMPTY, FFOL_SEL_FULL} ffol_sel_e;
   typedef logic [`FFOL_MAX_BITS-1:0] ffol_ofs_t;
   typedef struct packed {
      logic                    serial_mode;
      logic                    in_half;
      logic                    out_half;
      ffol_ofs_t               empty_ofs;
      ffol_ofs_t               full_ofs;
      ffol_sel_e               wr_sel;
      logic [1:0]              wr_seg;
      ffol_sel_e               rd_sel;
      logic [1:0]              rd_seg;
      logic [`FFOL_DATA_BITS-1:0] rdata;
      logic                    tog1;
      logic                    tog2;
      logic                    tog3;
      logic [1:0]              fwait;
      logic [1:0]              ewait;
      logic                    fvalid;
      logic                    evalid;
   } ffol_main_s;
   typedef struct packed {
      logic                    rst1;
      logic                    rst2;
      logic [1:0]              cfg1;
      logic [1:0]              cfg2;
      logic [`FFOL_IDX_BITS-1:0] idx;
      ffol_ofs_t               stage_e;
      ffol_ofs_t               stage_f;
      ffol_ofs_t               hold_e;
      ffol_ofs_t               hold_f;
      logic                    tog;
   } ffol_ser_s;
endpackage : ffol_pkg

//--- tb/ffol_serial_host.sv
// Host model of the serial offset link: makes the serial clock and shifts bit frames.
// Assumes the bench calls idle during resets so the link side sees edges.
`timescale 1ns/1ps
module ffol_serial_host (
   // Link pins
   output logic serial_clock,
   output logic serial_load_enable_n,
   output logic serial_in
);
   initial begin
      serial_clock = 1'b0;
      serial_load_enable_n = 1'b1;
      serial_in = 1'b0;
   end
   // The clock only runs inside these tasks, so it stands still between frames.
   task automatic tick(input logic en_n, input logic b);
      #3.3 serial_clock = 1'b1;
      serial_load_enable_n <= en_n;
      serial_in <= b;
      #2.7 serial_clock = 1'b0;
   endtask : tick
   // A released data line toggles so a stale bit can never look valid.
   task automatic idle(input int n);
      repeat (n) tick(1'b1, ~serial_in);
   endtask : idle
   task automatic shift(input logic [39:0] bits, input int n, input int pause_at);
      idle(4);
      for (int k = 0; k < n; k++) begin
         if (k == pause_at) idle(3);
         tick(1'b0, bits[k]);
      end
      idle(4);
   endtask : shift
endmodule : ffol_serial_host

//--- tb/ffol_props.sv
// Port checker of the flag offset loader.
// Assumes a single clock domain on clock; bound into ffol_top below.
`timescale 1ns/1ps
`include "ffol_map.svh"
module ffol_props (
   // Clock and reset
   input wire logic                       clock,
   input wire logic                       sys_rst,
   // Controls
   input wire logic                       master_reset,
   input wire logic                       partial_reset,
   input wire logic                       offset_load_strobe_n,
   input wire logic                       write_enable_n,
   input wire logic                       read_enable_n,
   // Outputs
   input wire logic [`FFOL_DATA_BITS-1:0] read_data_out,
   input wire logic [`FFOL_MAX_BITS-1:0]  empty_threshold_offset,
   input wire logic [`FFOL_MAX_BITS-1:0]  full_threshold_offset,
   input wire logic                       almost_empty_valid,
   input wire logic                       almost_full_valid,
   input wire logic                       serial_method,
   input wire logic                       memory_write,
   input wire logic                       memory_read
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_method_latched: assert property (!master_reset |=> $stable(serial_method))
      else $error("method changed outside master reset");
   a_mem_write: assert property (memory_write == (offset_load_strobe_n && !write_enable_n))
      else $error("memory write mismatch");
   a_mem_read: assert property (memory_read == (offset_load_strobe_n && !read_enable_n))
      else $error("memory read mismatch");
   a_strobe_keeps_offsets: assert property (
      offset_load_strobe_n && !serial_method && !master_reset
      |=> $stable(empty_threshold_offset) && $stable(full_threshold_offset))
      else $error("offsets changed with strobe high");
   a_read_holds_data: assert property (
      (read_enable_n || offset_load_strobe_n) && !partial_reset && !master_reset
      |=> $stable(read_data_out))
      else $error("read data changed without a read");
   a_partial_clears: assert property (
      partial_reset && read_enable_n && !master_reset |=> read_data_out == '0)
      else $error("partial reset left read data");
   a_master_drops_valid: assert property (
      master_reset |=> !almost_empty_valid && !almost_full_valid)
      else $error("valid survived master reset");
   a_full_valid_delay: assert property (disable iff (sys_rst || master_reset)
      serial_method && $changed(full_threshold_offset)
      |-> !almost_full_valid [*3] ##1 almost_full_valid)
      else $error("full valid timing wrong");
   a_empty_valid_delay: assert property (disable iff (sys_rst || master_reset)
      serial_method && $changed(empty_threshold_offset)
      |-> !almost_empty_valid [*3] ##1 almost_empty_valid)
      else $error("empty valid timing wrong");
   c_full_valid: cover property ($rose(almost_full_valid));
   c_mem_write: cover property (memory_write);
   c_offset_read: cover property (!offset_load_strobe_n && !read_enable_n);
endmodule : ffol_props
bind ffol_top ffol_props chk_u (.clock, .sys_rst, .master_reset, .partial_reset,
   .offset_load_strobe_n, .write_enable_n, .read_enable_n, .read_data_out,
   .empty_threshold_offset, .full_threshold_offset, .almost_empty_valid,
   .almost_full_valid, .serial_method, .memory_write, .memory_read);

//--- tb/test_fifo_flag_offset_loader.sv
// Self-checking bench of the flag offset loader: parallel, serial and readback paths.
// Assumes the serial host model drives the link pins; byte input port throughout.
`timescale 1ns/1ps
`include "ffol_map.svh"
`define FFOL_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_fifo_flag_offset_loader;
   logic clock = 1'b0, sys_rst = 1'b1, master_reset = 1'b0, partial_reset = 1'b0;
   logic serial_select = 1'b0, in_halfword = 1'b0, out_halfword = 1'b0;
   logic offset_load_strobe_n = 1'b0, write_enable_n = 1'b1, read_enable_n = 1'b1;
   logic [15:0] write_data_in = 16'h0000;
   logic serial_clock, serial_load_enable_n, serial_in;
   logic [15:0] read_data_out;
   logic [19:0] empty_threshold_offset, full_threshold_offset;
   logic almost_empty_valid, almost_full_valid, serial_method, memory_write, memory_read;
   logic [7:0]  wseq [6] = '{8'h12, 8'h34, 8'h05, 8'h78, 8'h9A, 8'h0B};
   logic [18:0] e_ofs = 19'h2_5A3C, f_ofs = 19'h6_C3A5;
   int failures = 0, n_compared = 0;
   ffol_top dut_u (.clock, .sys_rst, .serial_clock, .master_reset, .partial_reset,
      .serial_select, .in_halfword, .out_halfword, .offset_load_strobe_n, .write_enable_n,
      .read_enable_n, .write_data_in, .serial_load_enable_n, .serial_in, .read_data_out,
      .empty_threshold_offset, .full_threshold_offset, .almost_empty_valid,
      .almost_full_valid, .serial_method, .memory_write, .memory_read);
   ffol_serial_host host_u (.serial_clock, .serial_load_enable_n, .serial_in);
   initial begin
      forever #50 clock = ~clock;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic wr(input logic [15:0] d);
      @(posedge clock);
      write_enable_n <= 1'b0;
      write_data_in  <= d;
      @(posedge clock);
      write_enable_n <= 1'b1;
      cyc(1);
   endtask : wr
   // The idle cycle after each read keeps offset reads apart.
   task automatic rd(input logic [15:0] e);
      @(posedge clock);
      read_enable_n <= 1'b0;
      @(posedge clock);
      read_enable_n <= 1'b1;
      @(posedge clock);
      `FFOL_CHK(read_data_out, e)
   endtask : rd
   task automatic mreset(input logic ser, input logic oh);
      @(posedge clock);
      master_reset  <= 1'b1;
      serial_select <= ser;
      out_halfword  <= oh;
      host_u.idle(4);
      cyc(2);
      master_reset <= 1'b0;
   endtask : mreset
   task automatic final_report();
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   initial begin
      #200_000;
      failures++;
      final_report();
   end
   initial begin
      host_u.idle(4);
      cyc(3);
      sys_rst <= 1'b0;
      mreset(1'b0, 1'b0);
      wr({8'h00, wseq[0]});
      `FFOL_CHK(empty_threshold_offset, 20'h0_0012)
      @(posedge clock) offset_load_strobe_n <= 1'b1;
      wr(16'h00EE);
      `FFOL_CHK(empty_threshold_offset, 20'h0_0012)
      @(posedge clock) offset_load_strobe_n <= 1'b0;
      for (int i = 1; i < 6; i++) wr({8'h00, wseq[i]});
      `FFOL_CHK(empty_threshold_offset, 20'h5_3412)
      `FFOL_CHK(full_threshold_offset, 20'hB_9A78)
      cyc(3);
      `FFOL_CHK({almost_empty_valid, almost_full_valid}, 2'b11)
      wr(16'h00CD);
      `FFOL_CHK(empty_threshold_offset, 20'h5_34CD)
      rd(16'h00CD);
      @(posedge clock) offset_load_strobe_n <= 1'b1;
      rd(16'h00CD);
      @(posedge clock) offset_load_strobe_n <= 1'b0;
      for (int i = 1; i < 6; i++) rd({8'h00, wseq[i]});
      @(posedge clock) partial_reset <= 1'b1;
      @(posedge clock) partial_reset <= 1'b0;
      cyc(1);
      `FFOL_CHK(read_data_out, 16'h0000)
      rd(16'h00CD);
      @(posedge clock) serial_select <= 1'b1;
      cyc(2);
      `FFOL_CHK(serial_method, 1'b0)
      mreset(1'b1, 1'b1);
      cyc(1);
      `FFOL_CHK(serial_method, 1'b1)
      host_u.shift({2'b00, f_ofs, e_ofs}, 38, 17);
      cyc(8);
      `FFOL_CHK(empty_threshold_offset, {1'b0, e_ofs})
      `FFOL_CHK(full_threshold_offset, {1'b0, f_ofs})
      `FFOL_CHK({almost_empty_valid, almost_full_valid}, 2'b11)
      wr(16'hFFFF);
      `FFOL_CHK(full_threshold_offset, {1'b0, f_ofs})
      rd(e_ofs[15:0]);
      rd({13'h0000, e_ofs[18:16]});
      rd(f_ofs[15:0]);
      final_report();
   end
endmodule : test_fifo_flag_offset_loader
